// ---- src/abs_device_end.sv ----
// Drive end: character FIFO and absolute position sequencer
//
// Contract
// - Request low after power-up sends nothing
// - Host holds request high whole transfer
// - Host ready, counter cleared, after 100 ms
// - Eight position characters on phase A
// - Normal quadrature about 400 ms later
// - 9600 baud, 7 data, even, 1 stop
// - Frame: P, sign, five digits, CR
// - Serial count is divided position over 2^20
// - Remainder as initial pulses, 0.37 us each; here 14 cycles, 0.35 us at 40 MHz
// - A serial then pulses, B pulses, C origin
// - Origin width equals phase A width
// - Origin aligned to selectable A/B edge
// - Forward motion: B leads A always
// - Host never clears counter on origin
// - Host computes position minus reference
// - Request falling sends alarm contents
// - Host keeps request while motor powered
// - Servo-on ignored until transfer done
// - Host drops request before power-off
// - Scale mode at restart; incremental skips sequence
// - Initial pulses use the same divider
`timescale 1ns/1ps
`default_nettype none

module abs_char_fifo #(
	parameter int WIDTH = 7,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	input  wire logic             i_push_valid,
	input  wire logic [WIDTH-1:0] i_push_data,
	output logic                  o_push_ready,
	output logic                  o_pop_valid,
	output logic      [WIDTH-1:0] o_pop_data,
	input  wire logic             i_pop_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} fifo_t;

	fifo_t s;
	fifo_t n;
	logic  push;
	logic  pop;

	// Ready and valid reflect true fill level
	assign o_push_ready = (s.cnt != (AW+1)'(DEPTH));
	assign o_pop_valid  = (s.cnt != '0);
	assign o_pop_data   = s.mem[s.rp];

	// Pointer and count update
	always_comb begin
		n = s;
		push = i_push_valid && o_push_ready;
		pop = i_pop_ready && o_pop_valid;
		if (push) begin
			n.mem[s.wp] = i_push_data;
			n.wp = s.wp + 1'b1;
		end
		if (pop) begin
			n.rp = s.rp + 1'b1;
		end
		if (push && !pop) begin
			n.cnt = s.cnt + 1'b1;
		end else if (pop && !push) begin
			n.cnt = s.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

module abs_device_end
	import abs_pkg::*;
#(
	parameter int REQ_DELAY_CYCLES = abs_pkg::REQ_DELAY_CYC,
	parameter int SETTLE_CYCLES    = abs_pkg::SETTLE_CYC,
	parameter int BIT_CYCLES       = abs_pkg::BIT_CYC
) (
	input  wire logic                         I_CORE_CLK,
	input  wire logic                         I_ARST_N,
	abs_link_if.device                        LINK,
	input  wire logic                         I_SCALE_INCR,
	input  wire logic [abs_pkg::POS_W-1:0]    I_POS_MAG,
	input  wire logic                         I_POS_NEG,
	input  wire logic [abs_pkg::SHIFT_W-1:0]  I_RES_SHIFT,
	input  wire abs_pkg::origin_edge_t        I_ORIGIN_EDGE,
	input  wire logic                         I_ORIGIN_MARK,
	input  wire logic                         I_MOVE_STEP,
	input  wire logic                         I_MOVE_REV,
	input  wire logic                         I_SERVO_ON,
	input  wire logic [7:0]                   I_ALARM_CODE,
	output logic                              O_MOTOR_POWER
);
	import abs_pkg::*;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_DELAY = 8'h02,
		ST_CONV  = 8'h04,
		ST_SEND  = 8'h08,
		ST_DRAIN = 8'h10,
		ST_PULSE = 8'h20,
		ST_RUN   = 8'h40,
		ST_ALARM = 8'h80
	} dev_state_t;

	typedef struct packed {
		dev_state_t         st;
		logic               started;
		logic               incr_mode;
		logic [1:0]         req_sync;
		logic [31:0]        tmr;
		logic [2:0]         idx;
		logic [SER_W-1:0]   val;
		logic [2:0]         dig;
		logic [3:0]         dcnt;
		logic [4:0][3:0]    digs;
		logic               neg;
		logic [REM_W-1:0]   rem;
		logic [4:0]         pcnt;
		logic [15:0]        pres;
		logic [1:0]         q;
		logic               c;
		logic               arm;
		logic [9:0]         sh;
		logic [3:0]         nb;
		logic [31:0]        bt;
		logic               tx_busy;
		logic               tx;
		logic               power;
		logic [7:0]         alarm;
	} dev_t;

	dev_t                s;
	dev_t                n;
	logic                push_valid;
	logic [CHAR_W-1:0]   push_data;
	logic                push_ready;
	logic                pop_valid;
	logic [CHAR_W-1:0]   pop_data;
	logic                pop_ready;
	logic [POS_W-1:0]    div;
	logic [POS_W-21:0]   hi;
	logic [1:0]          nq;
	logic                ph_chg;
	logic                lvl;
	logic                serial_st;

	// Weight of the decimal digit being extracted
	function automatic logic [SER_W-1:0] pow_of(input logic [2:0] d);
		case (d)
			3'h0: pow_of = POW_10000;
			3'h1: pow_of = POW_1000;
			3'h2: pow_of = POW_100;
			3'h3: pow_of = POW_10;
			default: pow_of = POW_1;
		endcase
	endfunction

	// Character at a position of the position frame
	function automatic logic [CHAR_W-1:0] frame_char(input dev_t x);
		case (x.idx)
			3'h0: frame_char = CH_P;
			3'h1: frame_char = x.neg ? CH_MINUS : CH_PLUS;
			3'h7: frame_char = CH_CR;
			default: frame_char = hex_char(x.digs[3'(x.idx - 3'h2)]);
		endcase
	endfunction

	abs_char_fifo #(
		.WIDTH(CHAR_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk       (I_CORE_CLK),
		.i_arst_n    (I_ARST_N),
		.i_push_valid(push_valid),
		.i_push_data (push_data),
		.o_push_ready(push_ready),
		.o_pop_valid (pop_valid),
		.o_pop_data  (pop_data),
		.i_pop_ready (pop_ready)
	);

	assign serial_st = (s.st != ST_PULSE) && (s.st != ST_RUN);
	assign LINK.phase_a_out      = s.tx;
	assign LINK.phase_b_out      = s.q[0];
	assign LINK.origin_pulse_out = s.c;
	assign O_MOTOR_POWER         = s.power;

	// Sequencer, transmitter and quadrature generator
	always_comb begin
		n = s;
		push_valid = 1'b0;
		push_data = CH_CR;
		div = I_POS_MAG >> I_RES_SHIFT;
		hi = div[POS_W-1:REM_W];
		nq = s.q;
		// Request is a pin: two flops before use
		n.req_sync = {s.req_sync[0], LINK.absolute_request};
		pop_ready = !s.tx_busy;
		if (s.tx_busy) begin
			if (s.bt == '0) begin
				if (s.nb == '0) begin
					n.tx_busy = 1'b0;
				end else begin
					n.sh = {1'b1, s.sh[9:1]};
					n.nb = s.nb - 1'b1;
					n.bt = 32'(BIT_CYCLES - 1);
				end
			end else begin
				n.bt = s.bt - 1'b1;
			end
		end else if (pop_valid) begin
			n.sh = {1'b1, ^pop_data, pop_data, 1'b0};
			n.nb = 4'h9;
			n.bt = 32'(BIT_CYCLES - 1);
			n.tx_busy = 1'b1;
		end
		n.power = 1'b0;
		case (s.st)
			ST_IDLE: begin
				if (!s.started) begin
					n.started = 1'b1;
					n.incr_mode = I_SCALE_INCR;
					if (I_SCALE_INCR) begin
						n.st = ST_RUN;
						// Through nq, else the closing mux drops it
						nq = 2'b10;
					end
				end else if (s.req_sync[1]) begin
					n.st = ST_DELAY;
					n.tmr = '0;
					// Park B now, while A idles and host is not counting
					nq = 2'b10;
				end
			end
			ST_DELAY: begin
				n.tmr = s.tmr + 1'b1;
				if (!s.req_sync[1]) begin
					n.st = ST_IDLE;
				end else if (s.tmr == 32'(REQ_DELAY_CYCLES - 1)) begin
					n.val = (hi > (POS_W-REM_W)'(SERIAL_MAX))
						? SERIAL_MAX : hi[SER_W-1:0];
					n.rem = div[REM_W-1:0];
					n.neg = I_POS_NEG;
					n.dig = '0;
					n.dcnt = '0;
					n.st = ST_CONV;
				end
			end
			ST_CONV: begin
				// Decimal digits by repeated subtraction
				if (s.val >= pow_of(s.dig)) begin
					n.val = s.val - pow_of(s.dig);
					n.dcnt = s.dcnt + 1'b1;
				end else begin
					n.digs[s.dig] = s.dcnt;
					n.dcnt = '0;
					n.dig = s.dig + 1'b1;
					if (s.dig == 3'h4) begin
						n.idx = '0;
						n.st = ST_SEND;
					end
				end
			end
			ST_SEND: begin
				push_valid = 1'b1;
				push_data = frame_char(s);
				if (push_ready) begin
					n.idx = s.idx + 1'b1;
					if (s.idx == 3'(FRAME_LEN - 1)) begin
						n.st = ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				// Quadrature starts from the mark level, no false step
				if (!pop_valid && !s.tx_busy) begin
					n.st = ST_PULSE;
					n.tmr = '0;
					n.pcnt = '0;
					n.q = 2'b10;
				end
			end
			ST_PULSE: begin
				n.tmr = s.tmr + 1'b1;
				if (s.rem != '0) begin
					n.pcnt = s.pcnt + 1'b1;
					if (s.pcnt == 5'(PULSE_CYC - 1)) begin
						n.pcnt = '0;
						n.rem = s.rem - 1'b1;
						nq = quad_next(s.q, s.neg);
					end
				end else if (s.tmr >= 32'(SETTLE_CYCLES - 1)) begin
					n.st = ST_RUN;
					n.pres = '0;
				end
			end
			ST_RUN: begin
				n.power = I_SERVO_ON;
				if (I_MOVE_STEP) begin
					if (s.pres >= 16'((17'h1_0000 >> (5'h10 - 5'(I_RES_SHIFT)))
						- 17'h0_0001)) begin
						n.pres = '0;
						nq = quad_next(s.q, I_MOVE_REV);
					end else begin
						n.pres = s.pres + 1'b1;
					end
				end
				if (!s.incr_mode && !s.req_sync[1]) begin
					n.power = 1'b0;
					n.idx = '0;
					n.alarm = I_ALARM_CODE;
					n.st = ST_ALARM;
				end
			end
			ST_ALARM: begin
				push_valid = 1'b1;
				case (s.idx)
					3'h0: push_data = CH_A;
					3'h1: push_data = hex_char(s.alarm[7:4]);
					3'h2: push_data = hex_char(s.alarm[3:0]);
					default: push_data = CH_CR;
				endcase
				if (push_ready) begin
					n.idx = s.idx + 1'b1;
					if (s.idx == 3'(ALARM_LEN - 1)) begin
						n.st = ST_IDLE;
					end
				end
			end
			default: n.st = ST_IDLE;
		endcase
		n.q = (s.st == ST_DRAIN) ? n.q : nq;
		// A carries serial line, then quadrature
		n.tx = (n.tx_busy ? n.sh[0] : 1'b1);
		if (!serial_st || n.st == ST_PULSE || n.st == ST_RUN) begin
			n.tx = n.q[1];
		end
		// origin on the selected A/B edge
		ph_chg = I_ORIGIN_EDGE[1] ? (nq[0] ^ s.q[0]) : (nq[1] ^ s.q[1]);
		lvl = I_ORIGIN_EDGE[1] ? nq[0] : nq[1];
		// held until next edge of that phase
		if (s.c && ph_chg) begin
			n.c = 1'b0;
		end else if (s.arm && ph_chg && (lvl != I_ORIGIN_EDGE[0])) begin
			n.c = 1'b1;
			n.arm = 1'b0;
		end
		// New mark wins over its own consumption
		if (I_ORIGIN_MARK) begin
			n.arm = 1'b1;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.tx <= 1'b1;
		end else begin
			s <= n;
		end
	end
endmodule
`default_nettype wire

// ---- src/abs_pkg.sv ----
// Shared constants, types and helpers for the absolute position link
package abs_pkg;

	// Clock and timing
	localparam int CLK_HZ        = 40_000_000;
	localparam int REQ_DELAY_MS  = 100;
	localparam int SETTLE_MS     = 400;
	localparam int BAUD_BPS      = 9600;
	localparam int PULSE_NS      = 370;
	localparam int REQ_DELAY_CYC = CLK_HZ / 1000 * REQ_DELAY_MS;
	localparam int SETTLE_CYC    = CLK_HZ / 1000 * SETTLE_MS;
	// Bit time is a least time, so round up
	localparam int BIT_CYC       = (CLK_HZ + BAUD_BPS - 1) / BAUD_BPS;
	// Pulse period is approximate; round down, at least one cycle
	localparam int PULSE_CYC     = (PULSE_NS * (CLK_HZ / 1000_000) / 1000 < 1)
		? 1 : PULSE_NS * (CLK_HZ / 1000_000) / 1000;

	// Widths
	localparam int POS_W      = 41;
	localparam int SHIFT_W    = 4;
	localparam int REM_W      = 20;
	localparam int SER_W      = 17;
	localparam int CHAR_W     = 7;
	localparam int FIFO_DEPTH = 16;
	localparam int FRAME_LEN  = 8;
	localparam int ALARM_LEN  = 4;
	localparam int POSN_W     = 42;

	// Serial count limits and decimal weights
	localparam logic [SER_W-1:0] SERIAL_MAX = 17'h1_869F;
	localparam logic [SER_W-1:0] POW_10000  = 17'h0_2710;
	localparam logic [SER_W-1:0] POW_1000   = 17'h0_03E8;
	localparam logic [SER_W-1:0] POW_100    = 17'h0_0064;
	localparam logic [SER_W-1:0] POW_10     = 17'h0_000A;
	localparam logic [SER_W-1:0] POW_1      = 17'h0_0001;

	// Characters
	localparam logic [CHAR_W-1:0] CH_P     = 7'h50;
	localparam logic [CHAR_W-1:0] CH_A     = 7'h41;
	localparam logic [CHAR_W-1:0] CH_PLUS  = 7'h2B;
	localparam logic [CHAR_W-1:0] CH_MINUS = 7'h2D;
	localparam logic [CHAR_W-1:0] CH_CR    = 7'h0D;

	typedef enum logic [1:0] {
		EDGE_A_RISE = 2'h0,
		EDGE_A_FALL = 2'h1,
		EDGE_B_RISE = 2'h2,
		EDGE_B_FALL = 2'h3
	} origin_edge_t;

	// Hex digit to character
	function automatic logic [CHAR_W-1:0] hex_char(input logic [3:0] d);
		hex_char = (d < 4'hA) ? 7'(7'h30 + d) : 7'(7'h37 + d);
	endfunction

	// Character to hex digit
	function automatic logic [3:0] hex_val(input logic [CHAR_W-1:0] c);
		hex_val = (c >= 7'h41) ? 4'(c - 7'h37) : 4'(c - 7'h30);
	endfunction

	// Quadrature step, q = {a, b}; forward lets b lead a
	function automatic logic [1:0] quad_next(input logic [1:0] q,
		input logic rev);
		logic [1:0] f;
		case (q)
			2'b00: f = rev ? 2'b10 : 2'b01;
			2'b01: f = rev ? 2'b00 : 2'b11;
			2'b11: f = rev ? 2'b01 : 2'b10;
			default: f = rev ? 2'b11 : 2'b00;
		endcase
		quad_next = f;
	endfunction

endpackage

// ---- src/abs_link_if.sv ----
// Link wires between the drive end and the host end
`timescale 1ns/1ps
`default_nettype none
interface abs_link_if;
	logic absolute_request;
	logic phase_a_out;
	logic phase_b_out;
	logic origin_pulse_out;

	modport device(
		input  absolute_request,
		output phase_a_out,
		output phase_b_out,
		output origin_pulse_out
	);
	modport host(
		output absolute_request,
		input  phase_a_out,
		input  phase_b_out,
		input  origin_pulse_out
	);
endinterface
`default_nettype wire

// ---- src/abs_host_end.sv ----
// Host end: requests, receives and assembles absolute position
`timescale 1ns/1ps
`default_nettype none
module abs_host_end
	import abs_pkg::*;
#(
	parameter int REQ_DELAY_CYCLES = abs_pkg::REQ_DELAY_CYC,
	parameter int SETTLE_CYCLES    = abs_pkg::SETTLE_CYC,
	parameter int BIT_CYCLES       = abs_pkg::BIT_CYC
) (
	input  wire logic                        I_CORE_CLK,
	input  wire logic                        I_ARST_N,
	abs_link_if.host                         LINK,
	input  wire logic                        I_REQUEST,
	input  wire logic                        I_MOTOR_POWERED,
	input  wire logic signed [17:0]          I_REF_SERIAL,
	input  wire logic signed [20:0]          I_REF_PULSES,
	output logic                             O_POS_VALID,
	output logic signed [abs_pkg::POSN_W-1:0] O_POSITION,
	output logic                             O_FRAME_ERROR,
	output logic                             O_ALARM_VALID,
	output logic [7:0]                       O_ALARM_CODE,
	output logic                             O_SAFE_OFF
);
	import abs_pkg::*;

	typedef enum logic [5:0] {
		HS_IDLE   = 6'h01,
		HS_WAIT   = 6'h02,
		HS_RECV   = 6'h04,
		HS_SETTLE = 6'h08,
		HS_READY  = 6'h10,
		HS_ALARM  = 6'h20
	} host_state_t;

	typedef struct packed {
		host_state_t             st;
		logic                    req;
		logic                    safe;
		logic [1:0]              a_s;
		logic [1:0]              b_s;
		logic [1:0]              qp;
		logic signed [31:0]      cnt;
		logic [31:0]             tmr;
		logic                    rx_busy;
		logic [31:0]             bt;
		logic [3:0]              nb;
		logic [7:0]              sh;
		logic [2:0]              nch;
		logic [SER_W-1:0]        val;
		logic                    neg;
		logic                    valid;
		logic signed [POSN_W-1:0] pos;
		logic                    err;
		logic                    alarm_valid;
		logic [7:0]              alarm;
	} host_t;

	host_t                     s;
	host_t                     n;
	logic                      done;
	logic [CHAR_W-1:0]         ch;
	logic [1:0]                qc;
	logic signed [POSN_W-1:0]  pe;
	logic signed [POSN_W-1:0]  ref_v;

	assign LINK.absolute_request = s.req;
	assign O_POS_VALID   = s.valid;
	assign O_POSITION    = s.pos;
	assign O_FRAME_ERROR = s.err;
	assign O_ALARM_VALID = s.alarm_valid;
	assign O_ALARM_CODE  = s.alarm;
	assign O_SAFE_OFF    = s.safe;

	// Receiver, quadrature counter and request sequence
	always_comb begin
		n = s;
		done = 1'b0;
		ch = s.sh[6:0];
		n.alarm_valid = 1'b0;
		// Link pins pass two flops; qp is a third stage
		n.a_s = {s.a_s[0], LINK.phase_a_out};
		n.b_s = {s.b_s[0], LINK.phase_b_out};
		qc = {s.a_s[1], s.b_s[1]};
		n.qp = qc;
		// Serial receiver, mid-bit sampling
		if (s.rx_busy) begin
			if (s.bt == '0) begin
				n.bt = 32'(BIT_CYCLES - 1);
				n.nb = s.nb + 1'b1;
				if (s.nb == 4'h9) begin
					n.rx_busy = 1'b0;
					done = 1'b1;
					n.err = s.err | ^s.sh | !qc[1];
				end else if (s.nb != 4'h0) begin
					n.sh = {qc[1], s.sh[7:1]};
				end
			end else begin
				n.bt = s.bt - 1'b1;
			end
		end else if ((s.st == HS_RECV || s.st == HS_ALARM)
			&& s.qp[1] && !qc[1]) begin
			n.rx_busy = 1'b1;
			n.nb = '0;
			n.bt = 32'(BIT_CYCLES / 2);
		end
		if (s.st == HS_SETTLE || s.st == HS_READY) begin
			if (qc == quad_next(s.qp, 1'b0)) begin
				n.cnt = s.cnt + 32'sd1;
			end else if (qc == quad_next(s.qp, 1'b1)) begin
				n.cnt = s.cnt - 32'sd1;
			end
		end
		// value times 2^20 plus pulses, less reference
		pe = POSN_W'({s.val, 20'h0_0000});
		if (s.neg) begin
			pe = -pe;
		end
		ref_v = POSN_W'(I_REF_SERIAL) * (POSN_W'(1) <<< REM_W)
			+ POSN_W'(I_REF_PULSES);
		case (s.st)
			HS_IDLE: begin
				if (I_REQUEST) begin
					n.req = 1'b1;
					n.tmr = '0;
					n.err = 1'b0;
					n.valid = 1'b0;
					n.st = HS_WAIT;
				end
			end
			HS_WAIT: begin
				n.tmr = s.tmr + 1'b1;
				// standby and cleared counter at 100 ms
				if (s.tmr == 32'(REQ_DELAY_CYCLES - 1)) begin
					n.cnt = '0;
					n.nch = '0;
					n.val = '0;
					n.st = HS_RECV;
				end
			end
			HS_RECV: begin
				if (done) begin
					n.nch = s.nch + 1'b1;
					case (s.nch)
						3'h0: n.err = n.err | (ch != CH_P);
						3'h1: n.neg = (ch == CH_MINUS);
						3'h7: begin
							n.err = n.err | (ch != CH_CR);
							n.cnt = '0;
							n.tmr = '0;
							n.st = HS_SETTLE;
						end
						default: n.val = SER_W'({s.val, 3'h0}
							+ {s.val, 1'h0} + 20'(hex_val(ch)));
					endcase
				end
			end
			HS_SETTLE: begin
				n.tmr = s.tmr + 1'b1;
				if (s.tmr == 32'(SETTLE_CYCLES - 1)) begin
					n.st = HS_READY;
				end
			end
			HS_READY: begin
				n.valid = 1'b1;
				n.pos = pe + POSN_W'(s.cnt) - ref_v;
				if (!I_REQUEST && !I_MOTOR_POWERED) begin
					n.req = 1'b0;
					n.valid = 1'b0;
					n.nch = '0;
					n.st = HS_ALARM;
				end
			end
			HS_ALARM: begin
				if (done) begin
					n.nch = s.nch + 1'b1;
					case (s.nch)
						3'h0: n.err = n.err | (ch != CH_A);
						3'h1: n.alarm[7:4] = hex_val(ch);
						3'h2: n.alarm[3:0] = hex_val(ch);
						default: begin
							n.alarm_valid = 1'b1;
							n.st = HS_IDLE;
						end
					endcase
				end
			end
			default: n.st = HS_IDLE;
		endcase
		// power-off allowed only with request low
		n.safe = !n.req;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			s <= '0;
			s.st <= HS_IDLE;
			s.safe <= 1'b1;
			s.qp <= 2'b11;
		end else begin
			s <= n;
		end
	end
endmodule
`default_nettype wire

// ---- dv/abs_link_assertions.sv ----
// Assertions on the wires between drive end and host end
`timescale 1ns/1ps
`default_nettype none
module abs_link_assertions #(
	parameter int REQ_DELAY = 200,
	parameter int SETTLE    = 3000,
	parameter int BIT       = 16
) (
	input wire logic I_CORE_CLK,
	input wire logic I_ARST_N,
	input wire logic absolute_request,
	input wire logic phase_a_out,
	input wire logic phase_b_out,
	input wire logic origin_pulse_out
);
	localparam int DLY_LO   = REQ_DELAY;
	localparam int DLY_HI   = REQ_DELAY + 100;
	localparam int HOLD_MIN = REQ_DELAY + 80 * BIT + SETTLE;
	logic        b_moved;
	logic [15:0] hi_cnt;

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_ARST_N);

	// Request age, and whether B moved once the request settled
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			hi_cnt  <= '0;
			b_moved <= 1'b1;
		end else begin
			if (!absolute_request)
				hi_cnt <= '0;
			else if (hi_cnt != 16'hFFFF)
				hi_cnt <= hi_cnt + 16'h0001;
			if (absolute_request && hi_cnt == 16'(REQ_DELAY / 2))
				b_moved <= 1'b0;
			else if ($changed(phase_b_out))
				b_moved <= 1'b1;
		end
	end

	// A and B are a Gray pair, never both at once
	quad_gray_a: assert property (
		!($changed(phase_a_out) && $changed(phase_b_out)))
		else $error("A and B changed in the same cycle");
	origin_rise_a: assert property (
		$rose(origin_pulse_out)
		|-> $changed(phase_a_out) || $changed(phase_b_out))
		else $error("origin rose off a quadrature edge");
	origin_fall_a: assert property (
		$fell(origin_pulse_out)
		|-> $changed(phase_a_out) || $changed(phase_b_out))
		else $error("origin fell off a quadrature edge");
	req_hold_a: assert property (
		$fell(absolute_request) |-> hi_cnt >= 16'(HOLD_MIN))
		else $error("request dropped before transfer end");
	req_quiet_a: assert property (
		$rose(absolute_request) |=> phase_a_out [*8])
		else $error("phase A moved right after request");
	start_delay_a: assert property (
		$rose(absolute_request) |-> ##[DLY_LO:DLY_HI] !phase_a_out)
		else $error("no start bit after request delay");
	// Bits last BIT cycles; only the first eight are checked
	start_bit_a: assert property (
		absolute_request && !b_moved && $fell(phase_a_out)
		|-> !phase_a_out [*8])
		else $error("serial low bit too short");
	alarm_start_a: assert property (
		$fell(absolute_request) |-> ##[1:100] !phase_a_out)
		else $error("no alarm frame after request fell");

	cover property ($rose(absolute_request));
	cover property ($fell(absolute_request));
	cover property ($rose(origin_pulse_out));
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Bench: drive end and host end joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
	import abs_pkg::*;
	localparam int RQ = 200;
	localparam int ST = 3000;
	localparam int BT = 16;
	logic				clk, rst_n, incr, neg, mark, step, rev, son;
	logic				req, pwr, pv, ferr, av, safe, mpow, a_seen;
	logic [6:0]			c;
	logic [POS_W-1:0]		mag;
	logic [SHIFT_W-1:0]		sh;
	origin_edge_t			oe;
	logic [7:0]			alarm, acode, a_got;
	logic signed [17:0]		rser;
	logic signed [20:0]		rpul;
	logic signed [POSN_W-1:0]	pos;
	logic [31:0]			rs;
	int				err_count, num_checks, ser, rem, s;
	int				cyc = 0;
	longint				expv;
	realtime			t0;
	abs_link_if link();

	abs_device_end #(.REQ_DELAY_CYCLES(RQ), .SETTLE_CYCLES(ST),
		.BIT_CYCLES(BT)) u_abs_device_end (.I_CORE_CLK(clk),
		.I_ARST_N(rst_n), .LINK(link), .I_SCALE_INCR(incr),
		.I_POS_MAG(mag), .I_POS_NEG(neg), .I_RES_SHIFT(sh),
		.I_ORIGIN_EDGE(oe), .I_ORIGIN_MARK(mark), .I_MOVE_STEP(step),
		.I_MOVE_REV(rev), .I_SERVO_ON(son), .I_ALARM_CODE(alarm),
		.O_MOTOR_POWER(mpow));
	abs_host_end #(.REQ_DELAY_CYCLES(RQ), .SETTLE_CYCLES(ST),
		.BIT_CYCLES(BT)) u_abs_host_end (.I_CORE_CLK(clk),
		.I_ARST_N(rst_n), .LINK(link), .I_REQUEST(req),
		.I_MOTOR_POWERED(pwr), .I_REF_SERIAL(rser),
		.I_REF_PULSES(rpul), .O_POS_VALID(pv), .O_POSITION(pos),
		.O_FRAME_ERROR(ferr), .O_ALARM_VALID(av), .O_ALARM_CODE(acode),
		.O_SAFE_OFF(safe));
	abs_link_assertions #(.REQ_DELAY(RQ), .SETTLE(ST), .BIT(BT))
		u_abs_link_assertions (.I_CORE_CLK(clk), .I_ARST_N(rst_n),
		.absolute_request(link.absolute_request),
		.phase_a_out(link.phase_a_out), .phase_b_out(link.phase_b_out),
		.origin_pulse_out(link.origin_pulse_out));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction

	function automatic logic [6:0] hx(input logic [3:0] d);
		hx = (d < 4'hA) ? 7'(7'h30 + d) : 7'(7'h37 + d);
	endfunction

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bounded wait for a flag; running out counts as a miss
	task automatic wt(ref logic f);
		int n = 0;
		while (f !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk(f, 1'b1);
	endtask

	// Receive one character off phase A, sampled mid-bit
	task automatic rx(output logic [6:0] ch);
		logic [9:0] b;
		int n = 0;
		// Falling edges only: a flop output is settled there
		while (link.phase_a_out !== 1'b0 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		repeat (BT / 2) @(negedge clk);
		for (int i = 0; i < 10; i++) begin
			b[i] = link.phase_a_out;
			if (i < 9)
				repeat (BT) @(negedge clk);
		end
		ch = b[7:1];
		chk({b[9], b[0], ^b[8:1]}, 3'b100);
	endtask

	task automatic mv(input logic r);
		step = 1'b1;
		rev = r;
		@(negedge clk);
		step = 1'b0;
		repeat (20) @(negedge clk);
	endtask

	// Alarm strobe lasts one cycle, so latch it on every falling edge
	always @(negedge clk) begin
		cyc++;
		if (av === 1'b1) begin
			a_seen = 1'b1;
			a_got = acode;
		end
		if (cyc == 60000) begin
			err_count++;
			stop_test();
		end
	end

	initial begin
		{rst_n, incr, neg, mark, step, rev, son, req, pwr} = '0;
		{a_seen, mag, sh, alarm, rser, rpul} = '0;
		oe = EDGE_A_RISE;
		err_count = 0;
		num_checks = 0;
		rs = 32'h0000_349B;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		son = 1'b1;
		// Quiet link after reset: no request, nothing sent
		for (int k = 0; k < 18; k++) begin
			@(negedge clk);
			chk({link.phase_a_out, mpow}, 2'b10);
			chk({link.phase_b_out, safe, pv}, 3'b010);
		end
		// Absolute transfers with random position, sign, shift
		for (int t = 0; t < 3; t++) begin
			rs = xs(rs);
			ser = rs % 100000;
			rs = xs(rs);
			rem = 1 + rs[7:0];
			s = (t == 0) ? 0 : rs[9:8];
			neg = rs[10];
			oe = origin_edge_t'(rs[12:11]);
			alarm = rs[20:13];
			rpul = 21'(rs[30:21]);
			rser = 18'(t);
			sh = 4'(s);
			mag = 41'((((longint'(ser) << 20) | rem) << s) | (rs[31] & s));
			expv = longint'(ser) * 1048576 + rem;
			expv = (neg ? -expv : expv) - (longint'(rser) * 1048576 + rpul);
			a_seen = 1'b0;
			req = 1'b1;
			rx(c);
			t0 = $realtime;
			chk(c, CH_P);
			rx(c);
			chk(c, neg ? CH_MINUS : CH_PLUS);
			for (int k = 4; k >= 0; k--) begin
				rx(c);
				chk(c, 7'h30 + 7'((ser / 10 ** k) % 10));
			end
			rx(c);
			chk({c, mpow}, {CH_CR, 1'b0});
			// FIFO keeps the line busy: one idle cycle per character
			chk(int'(($realtime - t0) / 25.0), 7 * (10 * BT + 1));
			wt(pv);
			// Initial pulses may outlast the host's settle time
			wt(mpow);
			repeat (4) @(negedge clk);
			chk(pos, expv);
			chk(mpow, 1'b1);
			mark = 1'b1;
			@(negedge clk);
			mark = 1'b0;
			for (int k = 0; k < 6; k++) begin
				rs = xs(rs);
				mv(rs[0]);
				expv += rs[0] ? -1 : 1;
			end
			if (s == 0)
				chk(pos, expv);
			pwr = 1'b1;
			req = 1'b0;
			repeat (20) @(negedge clk);
			chk(link.absolute_request, 1'b1);
			pwr = 1'b0;
			// A still shows quadrature until the drive leaves normal run
			repeat (5) @(negedge clk);
			rx(c);
			t0 = $realtime;
			chk(c, CH_A);
			rx(c);
			chk(c, hx(alarm[7:4]));
			rx(c);
			chk(c, hx(alarm[3:0]));
			rx(c);
			chk(c, CH_CR);
			chk(int'(($realtime - t0) / 25.0), 3 * (10 * BT + 1));
			wt(a_seen);
			chk({a_got, safe, ferr}, {alarm, 2'b10});
			repeat (20) @(negedge clk);
		end
		// Incremental use: no request, steps go straight out
		incr = 1'b1;
		sh = '0;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		mv(1'b0);
		chk({link.phase_a_out, link.phase_b_out}, 2'b00);
		mv(1'b0);
		chk({link.phase_a_out, link.phase_b_out}, 2'b01);
		stop_test();
	end
endmodule
`default_nettype wire
